// ---- dxs_pkg.sv ----
// package: shared constants, types and structs for the dio dma sequencer
package dxs_pkg;

	// sample and counter widths
	localparam int DXS_DATA_W   = 32;
	localparam int DXS_CNT_W    = 24;
	localparam int DXS_DIV_W    = 16;
	localparam int DXS_OVR_W    = 32;

	// pacer reference and core clock rates
	localparam int DXS_CLK_HZ   = 250_000_000;
	localparam int DXS_REF_HZ   = 4_000_000;
	// cycles of the core clock per reference tick, rounded down
	localparam int DXS_REF_DIV  = DXS_CLK_HZ / DXS_REF_HZ;
	localparam logic [7:0] DXS_REF_LAST = 8'(DXS_REF_DIV - 1);

	// reset values and the unit divider step
	localparam logic [DXS_CNT_W-1:0] DXS_CNT_RST = 24'h00_0000;
	localparam logic [DXS_OVR_W-1:0] DXS_OVR_RST = 32'h0000_0000;
	localparam logic [DXS_DIV_W-1:0] DXS_DIV_ONE = 16'h0001;

	// input sampling sources
	typedef enum logic [1:0] {
		DXS_IN_PACER,
		DXS_IN_REQ_RISE,
		DXS_IN_REQ_FALL,
		DXS_IN_HANDSHAKE
	} dxs_in_src_t;

	// output pacing sources
	typedef enum logic [1:0] {
		DXS_OUT_PACER,
		DXS_OUT_PACER_REQ,
		DXS_OUT_HANDSHAKE
	} dxs_out_src_t;

	// pacer configuration
	typedef struct packed {
		logic                 pacer_chained;
		logic [DXS_DIV_W-1:0] first_divider;
		logic [DXS_DIV_W-1:0] cascade_divider;
	} dxs_pacer_cfg_t;

	// transfer status as seen by software
	typedef struct packed {
		logic                 running;
		logic [DXS_CNT_W-1:0] count;
	} dxs_status_t;

endpackage

// ---- dxs_pacer.sv ----
// pacer: reference prescaler and one or two chained dividers
`timescale 1ns/1ps
module dxs_pacer
	import dxs_pkg::*;
(
	input  wire logic           clock,     // core clock
	input  wire logic           reset_n,   // async reset, low
	input  wire logic           enable,    // runs while high
	input  wire dxs_pacer_cfg_t cfg,       // divider setup
	output logic                tick       // one-cycle pace pulse
);

	logic [7:0]           pre_reg;
	logic [DXS_DIV_W-1:0] first_reg;
	logic [DXS_DIV_W-1:0] casc_reg;
	logic                 tick_reg;
	wire                  ref_en;
	wire                  first_wrap;
	wire                  casc_wrap;
	wire                  casc_en;

	// 4 MHz reference enable from the core clock
	assign ref_en     = enable && (pre_reg == DXS_REF_LAST);
	assign first_wrap = ref_en && (first_reg <= DXS_DIV_ONE);
	// cascade stage counts wraps of the first stage
	assign casc_en    = first_wrap && cfg.pacer_chained;
	assign casc_wrap  = casc_en && (casc_reg <= DXS_DIV_ONE);
	assign tick       = tick_reg;

	// prescaler and first divider
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pre_reg   <= 8'h00;
			first_reg <= 16'h0000;
		end else if (!enable) begin
			pre_reg   <= 8'h00;
			first_reg <= 16'h0000;  // reload on the first reference tick
		end else begin
			pre_reg <= ref_en ? 8'h00 : pre_reg + 8'h01;
			if (first_wrap)
				first_reg <= cfg.first_divider;
			else if (ref_en)
				first_reg <= first_reg - DXS_DIV_ONE;
		end
	end

	// cascade divider and registered tick
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			casc_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else begin
			if (!enable)
				casc_reg <= 16'h0000;
			else if (casc_wrap)
				casc_reg <= cfg.cascade_divider;
			else if (casc_en)
				casc_reg <= casc_reg - DXS_DIV_ONE;
			tick_reg <= cfg.pacer_chained ? casc_wrap : first_wrap;
		end
	end

endmodule

// ---- dxs_sequencer.sv ----
// dio dma transfer sequencer: paced input capture and output playback
`timescale 1ns/1ps
module dxs_sequencer
	import dxs_pkg::*;
(
	input  wire logic                  clock,                // 250 MHz
	input  wire logic                  reset_n,              // async, low
	// input side control
	input  wire logic                  in_start,             // start pulse
	input  wire logic                  in_stop,              // stop pulse
	input  wire dxs_in_src_t           in_src,               // sample source
	input  wire logic                  double_buffer_enable, // circular mode
	input  wire logic [DXS_CNT_W-1:0]  in_length,            // samples
	input  wire dxs_pacer_cfg_t        in_pacer_cfg,         // input pacer
	input  wire logic                  half_drained,         // drain pulse
	output dxs_status_t                in_status,            // run and count
	output logic                       input_transfer_running, // 1 running
	output logic                       input_transfer_done,  // 1 finished
	output logic                       half_ready_flag,      // half full
	output logic                       half_ready_second,    // which half
	output logic [DXS_OVR_W-1:0]       overrun_counter,      // overruns
	// external input link
	input  wire logic                  in_req,               // request line
	output logic                       in_ack,               // acknowledge
	input  wire logic [DXS_DATA_W-1:0] din,                  // input port
	// memory write side
	output logic                       wr_valid,             // word pulse
	output logic [DXS_CNT_W-1:0]       wr_index,             // word index
	output logic [DXS_DATA_W-1:0]      wr_data,              // sample
	// output side control
	input  wire logic                  out_start,            // start pulse
	input  wire logic                  out_stop,             // stop pulse
	input  wire dxs_out_src_t          out_src,              // pace source
	input  wire logic                  out_repeat,           // continuous
	input  wire logic [DXS_CNT_W-1:0]  out_length,           // samples
	input  wire dxs_pacer_cfg_t        out_pacer_cfg,        // output pacer
	output dxs_status_t                out_status,           // run and count
	// memory read side
	output logic                       rd_req,               // fetch pulse
	output logic [DXS_CNT_W-1:0]       rd_index,             // word index
	input  wire logic [DXS_DATA_W-1:0] rd_data,              // fetched word
	// external output link
	output logic [DXS_DATA_W-1:0]      dout,                 // output port
	output logic                       out_req,              // request line
	input  wire logic                  out_ack               // acknowledge
);

	// ---------------- input side ----------------
	logic                  in_run_reg;
	logic                  in_db_reg;
	logic [DXS_CNT_W-1:0]  in_cnt_reg;
	logic [DXS_CNT_W-1:0]  in_idx_reg;
	logic                  req_d_reg;
	logic                  in_ack_reg;
	logic                  wr_valid_reg;
	logic [DXS_CNT_W-1:0]  wr_index_reg;
	logic [DXS_DATA_W-1:0] wr_data_reg;
	logic                  hr_reg;
	logic                  hr_second_reg;
	logic [DXS_OVR_W-1:0]  ovr_reg;
	wire                   in_tick;
	wire                   req_rise;
	wire                   req_fall;
	wire                   hs_take;
	wire                   in_take;
	wire                   in_last;
	wire [DXS_CNT_W-1:0]   half_len;
	wire                   half_end;
	wire                   first_end;

	dxs_pacer u_in_pacer (
		.clock   (clock),
		.reset_n (reset_n),
		.enable  (in_run_reg),
		.cfg     (in_pacer_cfg),
		.tick    (in_tick)
	);

	// request edges are taken as synchronous to the core clock
	assign req_rise = in_req && !req_d_reg;
	assign req_fall = !in_req && req_d_reg;
	// handshake: take the word on request while ack is low
	assign hs_take  = in_req && !in_ack_reg;
	assign in_take  = in_run_reg && !in_stop &&
		((in_src == DXS_IN_PACER     && in_tick)  ||
		 (in_src == DXS_IN_REQ_RISE  && req_rise) ||
		 (in_src == DXS_IN_REQ_FALL  && req_fall) ||
		 (in_src == DXS_IN_HANDSHAKE && hs_take));
	// length of 2^24 words is 2^26 bytes; all ones is the top index
	assign in_last   = (in_idx_reg == in_length - 24'h00_0001);
	assign half_len  = {1'b0, in_length[DXS_CNT_W-1:1]};
	assign first_end = (in_idx_reg == half_len - 24'h00_0001);
	assign half_end  = in_take && in_db_reg && (first_end || in_last);

	// input run state and counts
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			in_run_reg <= 1'b0;
			in_db_reg  <= 1'b0;
			in_cnt_reg <= DXS_CNT_RST;
			in_idx_reg <= DXS_CNT_RST;
		end else if (in_start) begin
			in_run_reg <= 1'b1;
			in_db_reg  <= double_buffer_enable;
			in_cnt_reg <= DXS_CNT_RST;
			in_idx_reg <= DXS_CNT_RST;
		end else if (in_stop) begin
			in_run_reg <= 1'b0;
		end else if (in_take) begin
			in_cnt_reg <= in_cnt_reg + 24'h00_0001;
			in_idx_reg <= in_last ? DXS_CNT_RST
				: in_idx_reg + 24'h00_0001;
			if (in_last && !in_db_reg)
				in_run_reg <= 1'b0;
		end
	end

	// captured sample towards memory, one word per take
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			req_d_reg    <= 1'b0;
			in_ack_reg   <= 1'b0;
			wr_valid_reg <= 1'b0;
			wr_index_reg <= DXS_CNT_RST;
			wr_data_reg  <= 32'h0000_0000;
		end else begin
			req_d_reg    <= in_req;
			// ack follows a handshake take and drops when the request drops
			in_ack_reg   <= (in_take && in_src == DXS_IN_HANDSHAKE) ||
				(in_ack_reg && in_req);
			wr_valid_reg <= in_take;
			if (in_take) begin
				wr_index_reg <= in_idx_reg;
				wr_data_reg  <= din;
			end
		end
	end

	// half-ready flag and overrun count; a new fill wins over a drain
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hr_reg        <= 1'b0;
			hr_second_reg <= 1'b0;
			ovr_reg       <= DXS_OVR_RST;
		end else if (in_start) begin
			hr_reg  <= 1'b0;
			ovr_reg <= DXS_OVR_RST;
		end else if (half_end) begin
			hr_reg        <= 1'b1;
			hr_second_reg <= in_last;
			// previous half still undrained when the next one fills
			if (hr_reg && !half_drained)
				ovr_reg <= ovr_reg + 32'h0000_0001;
		end else if (half_drained) begin
			hr_reg <= 1'b0;
		end
	end

	// running, done and count are meaningful in single-buffer mode only; the half-ready flag in double-buffer mode only
	assign input_transfer_running = in_run_reg && !in_db_reg;
	assign input_transfer_done    = !in_run_reg && !in_db_reg;
	assign in_status.running      = input_transfer_running;
	assign in_status.count        = in_db_reg ? DXS_CNT_RST
		: in_cnt_reg;
	assign half_ready_flag        = hr_reg && in_db_reg;
	assign half_ready_second      = hr_second_reg;
	assign overrun_counter        = ovr_reg;
	assign in_ack                 = in_ack_reg;
	assign wr_valid               = wr_valid_reg;
	assign wr_index               = wr_index_reg;
	assign wr_data                = wr_data_reg;

	// ---------------- output side ----------------
	logic                  out_run_reg;
	logic [DXS_CNT_W-1:0]  out_cnt_reg;
	logic [DXS_CNT_W-1:0]  out_idx_reg;
	logic                  out_req_reg;
	logic [DXS_DATA_W-1:0] dout_reg;
	logic                  rd_pend_reg;
	wire                   out_tick;
	wire                   out_take;
	wire                   out_last;
	wire                   hs_done;

	dxs_pacer u_out_pacer (
		.clock   (clock),
		.reset_n (reset_n),
		.enable  (out_run_reg),
		.cfg     (out_pacer_cfg),
		.tick    (out_tick)
	);

	// handshake: a sample goes out when the partner acks the request
	assign hs_done  = out_req_reg && out_ack;
	assign out_take = out_run_reg && !out_stop &&
		(((out_src == DXS_OUT_PACER ||
		   out_src == DXS_OUT_PACER_REQ) && out_tick) ||
		 (out_src == DXS_OUT_HANDSHAKE && hs_done));
	assign out_last = (out_idx_reg == out_length - 24'h00_0001);

	// output run state, position and count
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			out_run_reg <= 1'b0;
			out_cnt_reg <= DXS_CNT_RST;
			out_idx_reg <= DXS_CNT_RST;
		end else if (out_start) begin
			out_run_reg <= 1'b1;
			out_cnt_reg <= DXS_CNT_RST;
			out_idx_reg <= DXS_CNT_RST;
		end else if (out_stop) begin
			out_run_reg <= 1'b0;
		end else if (out_take) begin
			out_cnt_reg <= out_cnt_reg + 24'h00_0001;
			out_idx_reg <= out_last ? DXS_CNT_RST
				: out_idx_reg + 24'h00_0001;
			if (out_last && !out_repeat)
				out_run_reg <= 1'b0;
		end
	end

	// sample latch and request line; memory word is read one cycle later
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rd_pend_reg <= 1'b0;
			dout_reg    <= 32'h0000_0000;
			out_req_reg <= 1'b0;
		end else begin
			rd_pend_reg <= out_take;
			if (rd_pend_reg)
				dout_reg <= rd_data;
			// pacer-with-request shows the line while running;
			// handshake raises it and drops it on each ack
			if (!out_run_reg || out_stop)
				out_req_reg <= 1'b0;
			else if (out_src == DXS_OUT_PACER_REQ)
				out_req_reg <= 1'b1;
			else if (out_src == DXS_OUT_HANDSHAKE)
				out_req_reg <= !hs_done && !out_ack;
			else
				out_req_reg <= 1'b0;
		end
	end

	assign rd_req             = out_take;
	assign rd_index           = out_idx_reg;
	assign dout               = dout_reg;
	assign out_req            = out_req_reg;
	assign out_status.running = out_run_reg;
	assign out_status.count   = out_cnt_reg;

endmodule

// ---- dxs_sequencer_properties.sv ----
// checker: port-level timing properties of the dio dma sequencer
`timescale 1ns/1ps
module dxs_sequencer_properties
	import dxs_pkg::*;
(
	input wire logic                  clock,           // core clock
	input wire logic                  reset_n,         // async, low
	input wire logic                  in_stop,         // stop pulse
	input wire dxs_in_src_t           in_src,          // sample source
	input wire dxs_status_t           in_status,       // input status
	input wire logic [DXS_OVR_W-1:0]  overrun_counter, // overruns
	input wire logic                  in_req,          // request line
	input wire logic                  in_ack,          // acknowledge
	input wire logic [DXS_DATA_W-1:0] din,             // input port
	input wire logic                  wr_valid,        // word pulse
	input wire logic [DXS_DATA_W-1:0] wr_data,         // sample
	input wire logic                  out_stop,        // stop pulse
	input wire dxs_status_t           out_status,      // output status
	input wire logic                  rd_req,          // fetch pulse
	input wire logic [DXS_DATA_W-1:0] rd_data,         // fetched word
	input wire logic [DXS_DATA_W-1:0] dout             // output port
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// handshake take: request up, ack still low, running, no stop
	wire hs_take = in_status.running && in_src == DXS_IN_HANDSHAKE
		&& in_req && !in_ack && !in_stop;
	// stop and set both race a take, so each relation names its cause
	a_hs_ack_rise: assert property (hs_take |=> in_ack)
		else $error("ack missing after handshake request");
	a_hs_word_data: assert property (hs_take |=> wr_valid
		&& wr_data == $past(din)) else $error("handshake word not written");
	a_ack_release: assert property (in_ack && !in_req |=> !in_ack)
		else $error("ack held after request fell");
	a_in_stop_halts: assert property (in_stop |=> !in_status.running)
		else $error("input still running after stop");
	a_overrun_step: assert property ($changed(overrun_counter) |->
		overrun_counter == $past(overrun_counter) + 1 || overrun_counter == 0)
		else $error("overrun counter moved by more than one");
	a_dout_follows: assert property (rd_req |=> ##1
		dout == $past(rd_data)) else $error("output word not fetched word");
	a_out_count_step: assert property (rd_req && !out_stop |=>
		out_status.count == $past(out_status.count) + 1)
		else $error("output count did not advance");
	a_out_stop_halts: assert property (out_stop |=> !out_status.running)
		else $error("output still running after stop");
endmodule
bind dxs_sequencer dxs_sequencer_properties i_dxs_sequencer_properties (.*);

// ---- dxs_far_end.sv ----
// far-end model: request sender, output acknowledger, word store
`timescale 1ns/1ps
module dxs_far_end
	import dxs_pkg::*;
(
	input  wire logic                 clock,    // core clock
	input  wire logic                 reset_n,  // async, low
	input  wire logic                 ack_en,   // answer out_req
	output logic                      in_req,   // request line
	input  wire logic                 in_ack,   // acknowledge
	output logic [DXS_DATA_W-1:0]     din,      // input port
	input  wire logic                 out_req,  // output request
	output logic                      out_ack,  // output acknowledge
	input  wire logic                 rd_req,   // fetch pulse
	input  wire logic [DXS_CNT_W-1:0] rd_index, // word index
	output logic [DXS_DATA_W-1:0]     rd_data   // fetched word
);
	// idle levels at time zero
	initial begin
		in_req = 1'b0;
		din = 32'h0000_0000;
		out_ack = 1'b0;
		rd_data = 32'h0000_0000;
	end
	// hs: wait for ack at lvl; edge mode: hold for three cycles
	// ack is read just after the edge, never in the edge's own time step
	task automatic hold(input logic lvl, input logic hs);
		int k;
		k = 0;
		do begin
			@(posedge clock);
			#1;
			k++;
		end while (hs ? in_ack !== lvl : k < 3);
	endtask
	// one word by edge or handshake; data inverted once released
	task automatic send(input logic [DXS_DATA_W-1:0] d, input logic hs);
		@(posedge clock);
		#1;
		din = d;
		in_req = 1'b1;
		hold(1'b1, hs);
		in_req = 1'b0;
		hold(1'b0, hs);
		din = ~d;
	endtask
	// ack follows out_req; store word stale lines show the inverse
	always @(posedge clock) begin
		out_ack <= #1 reset_n && out_req && (ack_en || out_ack);
		rd_data <= #1 rd_req ? 32'h5a5a_0000 | 32'(rd_index) : ~rd_data;
	end
endmodule

// ---- dxs_sequencer_tb.sv ----
// testbench: scenario tasks for the dio dma sequencer
`timescale 1ns/1ps
module dxs_sequencer_tb;
	import dxs_pkg::*;
	logic                  clock = 1'b0, reset_n = 1'b0, ack_en = 1'b0;
	logic                  in_start = 1'b0, in_stop = 1'b0, out_repeat = 1'b0;
	logic                  out_start = 1'b0, out_stop = 1'b0;
	logic                  half_drained = 1'b0, double_buffer_enable = 1'b0;
	logic                  in_req, in_ack, out_req, out_ack, wr_valid, rd_req;
	logic                  input_transfer_running, input_transfer_done;
	logic                  half_ready_flag, half_ready_second;
	dxs_in_src_t           in_src = DXS_IN_PACER;
	dxs_out_src_t          out_src = DXS_OUT_PACER;
	dxs_pacer_cfg_t        in_pacer_cfg = {1'b0, 16'h0002, 16'h0002};
	dxs_pacer_cfg_t        out_pacer_cfg = {1'b0, 16'h0002, 16'h0002};
	dxs_status_t           in_status, out_status;
	logic [DXS_CNT_W-1:0]  in_length = 24'h00_0003, out_length = 24'h00_0003;
	logic [DXS_CNT_W-1:0]  wr_index, rd_index;
	logic [DXS_DATA_W-1:0] din, wr_data, rd_data, dout;
	logic [DXS_OVR_W-1:0]  overrun_counter;
	int                    mismatches = 0, check_count = 0, n;
	dxs_sequencer i_dxs_sequencer (.*);
	dxs_far_end i_dxs_far_end (.*);
	// core clock; a cycle ceiling cuts a hang short
	always #2 clock = ~clock;
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		print_verdict();
	end
	// compare, count, report
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tk(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tk(1);
		s = 1'b0;
	endtask
	// n ends one above the cycles since the previous written word
	task automatic wait_wr();
		for (n = 1; n == 1 || wr_valid !== 1'b1; n++) tk(1);
	endtask
	// paced single-block input, then chained pacer spacing
	task automatic t_pacer();
		pulse(in_start);
		check("in running", in_status.running, 1'b1);
		check("in done", input_transfer_done, 1'b0);
		wait_wr();
		wait_wr();
		check("single gap", n - 1, DXS_REF_DIV * 2);
		wait_wr();
		check("in finished", input_transfer_done, 1'b1);
		check("in count", in_status.count, 3);
		in_pacer_cfg = {1'b1, 16'h0002, 16'h0003};
		pulse(in_start);
		wait_wr();
		wait_wr();
		check("chained gap", n - 1, DXS_REF_DIV * 6);
		pulse(in_stop);
	endtask
	// edge and handshake sources, each stopped part way
	task automatic t_sources();
		in_length = 24'h00_000a;
		for (int s = 1; s < 4; s++) begin
			in_src = dxs_in_src_t'(s);
			pulse(in_start);
			i_dxs_far_end.send(32'h1e1e_0000 + s, s == 3);
			i_dxs_far_end.send(32'h2d2d_0000 + s, s == 3);
			check("src data", wr_data, 32'h2d2d_0000 + s);
			pulse(in_stop);
			tk(2);
			check("stop run", in_status.running, 1'b0);
			check("stop count", in_status.count, 2);
		end
	endtask
	// circular input on handshake: halves, overrun, drain, wrap
	task automatic t_double();
		double_buffer_enable = 1'b1;
		in_length = 24'h00_0004;
		pulse(in_start);
		check("db run", input_transfer_running, 1'b0);
		i_dxs_far_end.send(32'h0f0f_0000, 1'b1);
		i_dxs_far_end.send(32'h0f0f_0001, 1'b1);
		check("half one", {half_ready_flag, half_ready_second}, 2'b10);
		i_dxs_far_end.send(32'h0f0f_0002, 1'b1);
		i_dxs_far_end.send(32'h0f0f_0003, 1'b1);
		check("half two", {half_ready_flag, half_ready_second}, 2'b11);
		check("overrun", overrun_counter, 1);
		pulse(half_drained);
		check("drained", half_ready_flag, 1'b0);
		i_dxs_far_end.send(32'h0f0f_0004, 1'b1);
		check("wrap", wr_index, 0);
		check("db count", in_status.count, 0);
		pulse(in_stop);
		double_buffer_enable = 1'b0;
	endtask
	// one-shot output by pacer and handshake, then continuous until stop
	task automatic t_output();
		ack_en = 1'b1;
		for (int s = 0; s < 3; s += 2) begin
			out_src = dxs_out_src_t'(s);
			pulse(out_start);
			check("out run", out_status.running, 1'b1);
			while (out_status.running === 1'b1) tk(1);
			tk(2);
			check("out count", out_status.count, 3);
			check("out word", dout, 32'h5a5a_0002);
		end
		out_src = DXS_OUT_PACER_REQ;
		out_repeat = 1'b1;
		out_length = 24'h00_0002;
		pulse(out_start);
		while (out_status.count !== 24'h00_0005) tk(1);
		check("out req", out_req, 1'b1);
		check("repeat run", out_status.running, 1'b1);
		pulse(out_stop);
		tk(130);
		check("halt count", out_status.count, 5);
		check("wrap word", dout, 32'h5a5a_0000);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// reset, then scenarios; the double test reuses the handshake source
	initial begin
		tk(10);
		reset_n = 1'b1;
		tk(1);
		t_pacer();
		t_sources();
		t_double();
		t_output();
		print_verdict();
	end
endmodule
